// file: rtl/ssol_top.sv
/*
  Servo status and interlock logic: motor enable gating, positioning
  completed, speed coincidence and running outputs, with APB registers.
  Assumes position error and speeds come from logic on ref_clk, refreshed
  with a one-cycle ctrl_tick per control cycle; servo_on_n is a raw pin.
*/
// Implementation choices: the register addresses and the APB interface to the registers.
// Function
// - Mapping 0: motor disabled while servo-on input open, enabled while low.
// - Mapping 7: ignore servo-on input, motor always enabled.
// - Positioning-completed asserted low while position error within width.
// - Completed width accepts 0 to 250 pulses, default 7.
// - Completed width limited to 0 to 250.
// - Default routing puts positioning-completed on first terminal pair.
// - First pair carries speed match in speed mode, held asserted in torque.
// - Speed match asserted while reference-actual difference within width.
// - Speed match width 0 to 100 rpm, default 10.
// - Running asserted low while motor speed above detection level.
// - Detection level 1 to 10000 rpm, default 20.
// - Running also flagged to status display and monitor item.
// - Running routed by default to second terminal pair.
// - Signals sharing one terminal are ORed.
`timescale 1ns/10ps
`default_nettype none
`include "ssol_regs.svh"
module ssol_top (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        servo_on_n,
  input  wire logic        ctrl_tick,
  input  wire logic [15:0] position_error,
  input  wire logic [15:0] speed_ref,
  input  wire logic [15:0] speed_act,
  output var  logic        motor_enable,
  output var  logic [2:0]  out_term_n,
  output var  logic        run_display,
  output var  logic        running_monitor_item
);
  import ssol_pkg::*;

  // ==========================================
  // Reset state
  localparam ssol_state_s ST_RST = '{
    sync1:       1'b1,
    sync2:       1'b1,
    mapping:     `SSOL_MAP_DEFAULT,
    mode:        MODE_POS,
    done_width:  `SSOL_DWIDTH_RST,
    match_width: `SSOL_MWIDTH_RST,
    level:       `SSOL_LEVEL_RST,
    outsel:      `SSOL_OUTSEL_RST,
    done:        1'b0,
    match:       1'b0,
    run:         1'b0,
    motor_en:    1'b0,
    term_n:      3'b111,
    run_disp:    1'b0,
    run_mon:     1'b0,
    pready:      1'b0,
    pslverr:     1'b0,
    prdata:      32'h0000_0000
  };

  ssol_state_s st_q;
  ssol_state_s st_d;

  logic        sig_a;
  logic [1:0]  idx_a;
  logic [1:0]  idx_r;
  logic        hit;
  logic [16:0] pos_mag;
  logic [16:0] spd_mag;
  logic [16:0] err_mag;
  logic [17:0] spd_diff;
  logic        take;

  // ==========================================
  // Helpers
  // Magnitude at 17 bits so that the most negative input still fits
  function automatic logic [16:0] mag17(input logic [16:0] v);
    mag17 = v[16] ? 17'(-v) : v;
  endfunction : mag17

  // Select 0 keeps the default pair; 1 to 3 name a pair directly
  function automatic logic [1:0] pair_of(input logic [1:0] sel,
                                         input logic [1:0] dflt);
    pair_of = (sel == 2'h0) ? dflt : 2'(sel - 2'h1);
  endfunction : pair_of

  assign pos_mag = mag17({position_error[15], position_error});
  assign spd_mag = mag17({speed_act[15], speed_act});
  // Eighteen bits, one more than opposite full-scale speeds need
  assign spd_diff = {{2{speed_ref[15]}}, speed_ref} - {{2{speed_act[15]}}, speed_act};
  assign err_mag  = spd_diff[17] ? 17'(-spd_diff) : spd_diff[16:0];
  assign take    = psel & penable & st_q.pready;

  // ==========================================
  // Next state
  always_comb begin
    st_d = st_q;
    hit  = 1'b0;

    // Pin crosses two flops before use
    st_d.sync1 = servo_on_n;
    st_d.sync2 = st_q.sync1;

    // Other mappings fall back to the pin
    if (st_q.mapping == `SSOL_MAP_FORCE_ON) begin
      st_d.motor_en = 1'b1;
    end else begin
      st_d.motor_en = ~st_q.sync2;
    end

    // Compared only on the control tick
    if (ctrl_tick) begin
      st_d.done  = (pos_mag <= 17'(st_q.done_width));
      st_d.match = (err_mag <= 17'(st_q.match_width));
      st_d.run   = (spd_mag > 17'(st_q.level));
      st_d.run_disp = st_d.run;
      st_d.run_mon  = st_d.run;
    end

    // First pair signal follows the control mode
    unique case (st_q.mode)
      MODE_POS: sig_a = st_q.done;
      MODE_SPD: sig_a = st_q.match;
      MODE_TRQ: sig_a = 1'b1;
      default:  sig_a = 1'b0;
    endcase
    idx_a = pair_of(st_q.outsel[`SSOL_SEL_DONE_LSB +: 2], 2'h0);
    idx_r = pair_of(st_q.outsel[`SSOL_SEL_RUN_LSB +: 2], 2'h1);
    for (int k = 0; k < 3; k++) begin
      hit = ((idx_a == 2'(k)) & sig_a) | ((idx_r == 2'(k)) & st_q.run);
      st_d.term_n[k] = ~hit;
    end

    // APB: answer in the second access cycle
    st_d.pready  = psel & penable & ~st_q.pready;
    st_d.pslverr = 1'b0;
    if (psel & penable & ~st_q.pready) begin
      st_d.prdata = 32'h0000_0000;
      unique case (paddr)
        `SSOL_ADDR_CTRL: begin
          st_d.prdata = {26'h0, st_q.mode, st_q.mapping};
        end
        `SSOL_ADDR_DWIDTH: begin
          st_d.prdata = {24'h0, st_q.done_width};
        end
        `SSOL_ADDR_MWIDTH: begin
          st_d.prdata = {25'h0, st_q.match_width};
        end
        `SSOL_ADDR_LEVEL: begin
          st_d.prdata = {18'h0, st_q.level};
        end
        `SSOL_ADDR_OUTSEL: begin
          st_d.prdata = {16'h0, st_q.outsel};
        end
        `SSOL_ADDR_STATUS: begin
          st_d.prdata = {26'h0, st_q.run_mon, st_q.run, st_q.match,
                         st_q.done, st_q.motor_en, ~st_q.sync2};
        end
        default: begin
          st_d.pslverr = 1'b1;
        end
      endcase
    end

    // Writes land only at the completing edge
    if (take & pwrite) begin
      unique case (paddr)
        `SSOL_ADDR_CTRL: begin
          st_d.mapping = pwdata[`SSOL_CTRL_MAP_LSB +: 4];
          st_d.mode    = ssol_mode_e'(pwdata[`SSOL_CTRL_MOD_LSB +: 2]);
        end
        `SSOL_ADDR_DWIDTH: begin
          // Wide widths keep the output on during slow moves
          if (pwdata[31:0] > 32'(`SSOL_DWIDTH_MAX)) begin
            st_d.done_width = `SSOL_DWIDTH_MAX;
          end else begin
            st_d.done_width = pwdata[7:0];
          end
        end
        `SSOL_ADDR_MWIDTH: begin
          if (pwdata[31:0] > 32'(`SSOL_MWIDTH_MAX)) begin
            st_d.match_width = `SSOL_MWIDTH_MAX;
          end else begin
            st_d.match_width = pwdata[6:0];
          end
        end
        `SSOL_ADDR_LEVEL: begin
          if (pwdata[31:0] > 32'(`SSOL_LEVEL_MAX)) begin
            st_d.level = `SSOL_LEVEL_MAX;
          end else if (pwdata[31:0] < 32'(`SSOL_LEVEL_MIN)) begin
            st_d.level = `SSOL_LEVEL_MIN;
          end else begin
            st_d.level = pwdata[13:0];
          end
        end
        `SSOL_ADDR_OUTSEL: begin
          st_d.outsel = pwdata[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================
  // Outputs
  assign prdata               = st_q.prdata;
  assign pready               = st_q.pready;
  assign pslverr              = st_q.pslverr;
  assign motor_enable         = st_q.motor_en;
  assign out_term_n           = st_q.term_n;
  assign run_display          = st_q.run_disp;
  assign running_monitor_item = st_q.run_mon;

  // ==========================================
  // Checks
  enable_pin_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_q.mapping == `SSOL_MAP_DEFAULT) |=> (motor_enable == !$past(st_q.sync2)))
    else $error("motor enable does not follow servo-on pin");

  enable_force_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_q.mapping == `SSOL_MAP_FORCE_ON) |=> motor_enable)
    else $error("forced mapping did not enable motor");

  done_cmp_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl_tick |=> (st_q.done == ($past(pos_mag) <= 17'($past(st_q.done_width)))))
    else $error("completed flag disagrees with error and width");

  width_clamp_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_q.done_width <= `SSOL_DWIDTH_MAX) && (st_q.match_width <= `SSOL_MWIDTH_MAX))
    else $error("width above its limit");

  match_cmp_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl_tick |=> (st_q.match == ($past(err_mag) <= 17'($past(st_q.match_width)))))
    else $error("speed match flag wrong");

  run_cmp_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl_tick |=> (st_q.run == ($past(spd_mag) > 17'($past(st_q.level)))))
    else $error("running flag wrong");

  run_flags_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl_tick |=> (run_display == ($past(spd_mag) > 17'($past(st_q.level))))
                  && (running_monitor_item == run_display))
    else $error("running display or monitor item wrong");

  dwidth_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    take && pwrite && (paddr == `SSOL_ADDR_DWIDTH) && (pwdata <= 32'(`SSOL_DWIDTH_MAX))
    |=> ({24'h0, st_q.done_width} == $past(pwdata)))
    else $error("completed width write not taken");

  level_range_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_q.level >= `SSOL_LEVEL_MIN) && (st_q.level <= `SSOL_LEVEL_MAX))
    else $error("detection level out of range");

  torque_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_q.mode == MODE_TRQ) && (st_q.outsel[1:0] == 2'h0) |=> !out_term_n[0])
    else $error("first pair not held in torque mode");

  run_route_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_q.run && (st_q.outsel[5:4] == 2'h0) |=> !out_term_n[1])
    else $error("running not on second pair");

  tick_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !ctrl_tick |=> $stable(st_q.done) && $stable(st_q.match) && $stable(running_monitor_item))
    else $error("result changed without control tick");

  done_route_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_q.mode == MODE_POS) && (st_q.outsel[1:0] == 2'h0) && (st_q.outsel[5:4] != 2'h1)
    |=> (out_term_n[0] == !$past(st_q.done)))
    else $error("completed not on first pair");

  speed_route_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_q.mode == MODE_SPD) && (st_q.outsel[1:0] == 2'h0) && (st_q.outsel[5:4] != 2'h1)
    |=> (out_term_n[0] == !$past(st_q.match)))
    else $error("speed match not on first pair");

  or_share_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_q.mode == MODE_POS) && (st_q.outsel[1:0] == 2'h2) && (st_q.outsel[5:4] == 2'h0)
    |=> (out_term_n[1] == !($past(st_q.done) || $past(st_q.run))))
    else $error("shared pair is not the OR of its signals");

  run_pair3_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_q.run && (st_q.outsel[5:4] == 2'h3) |=> !out_term_n[2])
    else $error("running not on selected third pair");
endmodule : ssol_top
`default_nettype wire

// file: rtl/ssol_regs.svh
/*
  Offsets, field positions, reset values and limits of the servo status block.
  Assumes byte addresses on an APB bus with 32-bit data.
*/
`ifndef SSOL_REGS_SVH
`define SSOL_REGS_SVH
// ==========================================
// Register offsets
`define SSOL_ADDR_CTRL    8'h00
`define SSOL_ADDR_DWIDTH  8'h04
`define SSOL_ADDR_MWIDTH  8'h08
`define SSOL_ADDR_LEVEL   8'h0c
`define SSOL_ADDR_OUTSEL  8'h10
`define SSOL_ADDR_STATUS  8'h14
// ==========================================
// Field positions
`define SSOL_CTRL_MAP_LSB 0
`define SSOL_CTRL_MOD_LSB 4
`define SSOL_SEL_DONE_LSB 0
`define SSOL_SEL_RUN_LSB  4
// ==========================================
// Reset values and limits
`define SSOL_MAP_DEFAULT  4'h0
`define SSOL_MAP_FORCE_ON 4'h7
`define SSOL_DWIDTH_RST   8'h07
`define SSOL_DWIDTH_MAX   8'hfa
`define SSOL_MWIDTH_RST   7'h0a
`define SSOL_MWIDTH_MAX   7'h64
`define SSOL_LEVEL_RST    14'h0014
`define SSOL_LEVEL_MIN    14'h0001
`define SSOL_LEVEL_MAX    14'h2710
`define SSOL_OUTSEL_RST   16'h0000
`endif

// file: rtl/ssol_pkg.sv
/*
  Types of the servo status block.
  Assumes nothing beyond the block itself.
*/
`default_nettype none
package ssol_pkg;
  // ==========================================
  // Control modes
  typedef enum logic [1:0] {
    MODE_POS = 2'b00,
    MODE_SPD = 2'b01,
    MODE_TRQ = 2'b10
  } ssol_mode_e;

  // ==========================================
  // Whole state of the block
  typedef struct packed {
    logic        sync1;
    logic        sync2;
    logic [3:0]  mapping;
    ssol_mode_e  mode;
    logic [7:0]  done_width;
    logic [6:0]  match_width;
    logic [13:0] level;
    logic [15:0] outsel;
    logic        done;
    logic        match;
    logic        run;
    logic        motor_en;
    logic [2:0]  term_n;
    logic        run_disp;
    logic        run_mon;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ssol_state_s;
endpackage : ssol_pkg
`default_nettype wire

// file: sim/ssol_host_model.sv
/*
  Host controller stand-in for the servo status block.
  Assumes the block's terminal outputs are registered on ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module ssol_host_model (
  input  wire logic       ref_clk,
  input  wire logic       want_on,
  input  wire logic [2:0] out_term_n,
  output var  logic       servo_on_n,
  output var  logic       interlock_ok
);
  // ==========================================
  // Pin and interlock
  initial servo_on_n = 1'b1;
  initial interlock_ok = 1'b0;
  // Pin only moved for enable tests; motion itself comes by reference
  always @(posedge ref_clk) begin
    servo_on_n <= ~want_on;
    interlock_ok <= ~out_term_n[0]; // Wait on pair 1 before going on
  end
endmodule : ssol_host_model
`default_nettype wire

// file: sim/test_ssol_top.sv
/*
  Self-checking bench of the servo status block.
  Assumes the host model beside it and one APB wait state or more.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ssol_regs.svh"
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, v); end end
module test_ssol_top;
  import ssol_pkg::*;
  logic        ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, ctrl_tick = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic        pready, pslverr, e, servo_on_n, motor_enable, run_display, running_monitor_item;
  logic        want_on = 0, interlock_ok;
  logic [15:0] position_error = 0, speed_ref = 0, speed_act = 0;
  logic [2:0]  out_term_n;
  int          err_count = 0, checked = 0;
  always #20 ref_clk = ~ref_clk;
  ssol_top ssol_top_i (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .servo_on_n, .ctrl_tick, .position_error, .speed_ref, .speed_act,
    .motor_enable, .out_term_n, .run_display, .running_monitor_item);
  ssol_host_model ssol_host_model_i (.ref_clk, .want_on, .out_term_n, .servo_on_n, .interlock_ok);
  // ==========================================
  // Bus and tick tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 50);
    if (pready !== 1'b1) err_count++; // A lost answer is a mismatch
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  // Data held after the tick so late sampling cannot hide a slip
  task automatic tick(input logic [15:0] pe, input logic [15:0] sr, input logic [15:0] sa);
    @(posedge ref_clk);
    position_error <= pe; speed_ref <= sr; speed_act <= sa; ctrl_tick <= 1;
    @(posedge ref_clk);
    ctrl_tick <= 0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // ==========================================
  // Scenarios
  task automatic t_regs;
    apb(0, `SSOL_ADDR_DWIDTH, 0); `CHK("dwidth", 32'h7, r)
    apb(0, `SSOL_ADDR_MWIDTH, 0); `CHK("mwidth", 32'ha, r)
    apb(0, `SSOL_ADDR_LEVEL, 0); `CHK("level", 32'h14, r)
    apb(0, `SSOL_ADDR_OUTSEL, 0); `CHK("outsel", 32'h0, r)
    apb(1, `SSOL_ADDR_DWIDTH, 32'hff); apb(0, `SSOL_ADDR_DWIDTH, 0); `CHK("dw clamp", 32'hfa, r)
    apb(1, `SSOL_ADDR_MWIDTH, 32'h7f); apb(0, `SSOL_ADDR_MWIDTH, 0); `CHK("mw clamp", 32'h64, r)
    apb(1, `SSOL_ADDR_LEVEL, 32'h0); apb(0, `SSOL_ADDR_LEVEL, 0); `CHK("lv low", 32'h1, r)
    apb(1, `SSOL_ADDR_LEVEL, 32'h3fff); apb(0, `SSOL_ADDR_LEVEL, 0); `CHK("lv high", 32'h2710, r)
    apb(0, 8'h18, 0); `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, r)
    $display("test regs finished");
  endtask : t_regs
  task automatic t_servo;
    repeat (6) @(posedge ref_clk); #1;
    `CHK("en pin open", 1'b0, motor_enable)
    want_on <= 1; repeat (6) @(posedge ref_clk); #1;
    `CHK("en pin low", 1'b1, motor_enable)
    want_on <= 0; repeat (6) @(posedge ref_clk); #1;
    `CHK("en released", 1'b0, motor_enable)
    apb(1, `SSOL_ADDR_CTRL, 32'h7); repeat (3) @(posedge ref_clk); #1;
    `CHK("en forced", 1'b1, motor_enable)
    apb(0, `SSOL_ADDR_STATUS, 0); `CHK("status", 32'h2, r)
    apb(1, `SSOL_ADDR_CTRL, 32'h0);
    $display("test servo finished");
  endtask : t_servo
  task automatic t_done;
    apb(1, `SSOL_ADDR_DWIDTH, 32'h7); // Small width kept
    tick(16'h0007, 0, 0); `CHK("done at width", 1'b0, out_term_n[0])
    @(posedge ref_clk); #1; `CHK("interlock", 1'b1, interlock_ok)
    tick(16'hfff8, 0, 0); `CHK("done over", 1'b1, out_term_n[0])
    tick(16'hfff9, 0, 0); `CHK("done neg", 1'b0, out_term_n[0])
    @(posedge ref_clk); position_error <= 16'h0100; repeat (4) @(posedge ref_clk); #1;
    `CHK("no tick hold", 1'b0, out_term_n[0])
    $display("test done finished");
  endtask : t_done
  task automatic t_speed;
    apb(1, `SSOL_ADDR_CTRL, 32'h10);
    tick(16'h0100, 16'd2000, 16'd1900); `CHK("match edge", 1'b0, out_term_n[0])
    tick(16'h0000, 16'd2000, 16'd1899); `CHK("match out", 1'b1, out_term_n[0])
    apb(1, `SSOL_ADDR_CTRL, 32'h20);
    tick(16'h0100, 16'd2000, 16'd0); `CHK("torque on", 1'b0, out_term_n[0])
    apb(1, `SSOL_ADDR_CTRL, 32'h30);
    tick(0, 0, 0); `CHK("mode off", 1'b1, out_term_n[0])
    apb(1, `SSOL_ADDR_CTRL, 32'h0);
    $display("test speed finished");
  endtask : t_speed
  task automatic t_run;
    apb(1, `SSOL_ADDR_LEVEL, 32'h14);
    tick(0, 0, 16'd21); `CHK("run pair2", 1'b0, out_term_n[1])
    `CHK("run disp", 1'b1, run_display)
    `CHK("run mon", 1'b1, running_monitor_item)
    tick(0, 0, 16'hffeb); `CHK("run rev", 1'b0, out_term_n[1])
    tick(0, 0, 16'd20); `CHK("run at lvl", 1'b1, out_term_n[1])
    `CHK("disp off", 1'b0, run_display)
    $display("test run finished");
  endtask : t_run
  task automatic t_route;
    apb(1, `SSOL_ADDR_OUTSEL, 32'h2);
    tick(0, 0, 0); `CHK("or done", 3'b101, out_term_n)
    tick(16'h0100, 0, 16'hffce); `CHK("or run", 3'b101, out_term_n)
    tick(16'h0100, 0, 0); `CHK("or none", 3'b111, out_term_n)
    apb(1, `SSOL_ADDR_OUTSEL, 32'h31);
    tick(0, 0, 16'd50); `CHK("pair3 run", 3'b010, out_term_n)
    apb(1, `SSOL_ADDR_OUTSEL, 32'h0);
    tick(0, 0, 0); `CHK("default pair1", 3'b110, out_term_n)
    $display("test route finished");
  endtask : t_route
  // ==========================================
  // Main sequence and watchdog
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 0;
    t_regs();
    t_servo();
    t_done();
    t_speed();
    t_run();
    t_route();
    conclude();
  end
  // About 200 cycles expected; a thirtyfold margin
  initial begin
    #240000;
    err_count++;
    conclude();
  end
endmodule : test_ssol_top
`default_nettype wire
